/* File: hdl/line_modes_pkg.sv */
// Constants, encodings and register map for the sensor node line block
package line_modes_pkg;

  // Line count and field widths
  localparam int unsigned NUM_LINES_DEF = 4;
  localparam int unsigned MODE_W        = 4;
  localparam int unsigned EDGE_W        = 2;

  // Function select codes, one field of MODE_W bits per line
  typedef enum logic [3:0] {
    MODE_HOST       = 4'h0,
    MODE_IN_SINK24  = 4'h1,
    MODE_IN_SINK_PM = 4'h2,
    MODE_IN_LOGIC   = 4'h3,
    MODE_IN_CONTACT = 4'h4,
    MODE_OUT_SINK   = 4'h5,
    MODE_OUT_SOURCE = 4'h6,
    MODE_OUT_OC_PU  = 4'h7,
    MODE_OUT_PUSH   = 4'h8
  } line_mode_t;

  // Event edge codes, one field of EDGE_W bits per line
  typedef enum logic [1:0] {
    EDGE_OFF  = 2'h0,
    EDGE_FALL = 2'h1,
    EDGE_RISE = 2'h2
  } edge_sel_t;

  // On-demand sample sequence
  typedef enum logic [1:0] {
    SMP_IDLE    = 2'b00,
    SMP_SETTLE  = 2'b01,
    SMP_CAPTURE = 2'b11
  } smp_state_t;

  // Register byte offsets
  localparam logic [7:0] OFF_MODE   = 8'h00;
  localparam logic [7:0] OFF_OUT    = 8'h04;
  localparam logic [7:0] OFF_EDGE   = 8'h08;
  localparam logic [7:0] OFF_IN     = 8'h0C;
  localparam logic [7:0] OFF_SAMPLE = 8'h10;
  localparam logic [7:0] OFF_FLAG   = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;

  // Field positions
  localparam int unsigned SAMPLE_START_BIT = 0;
  localparam int unsigned SAMPLE_BUSY_BIT  = 0;
  localparam int unsigned STATUS_SUPPLY_BIT = 0;
  localparam int unsigned STATUS_BUSY_BIT   = 1;

  // Reset values
  localparam logic [31:0] RST_MODE = 32'h0000_0000;
  localparam logic [31:0] RST_OUT  = 32'h0000_0000;
  localparam logic [31:0] RST_EDGE = 32'h0000_0000;

  // Settle time of the load before an on-demand sample
  localparam int unsigned SETTLE_TIME_NS    = 100000;
  localparam int unsigned CLK_PERIOD_NS     = 8;
  localparam int unsigned SETTLE_CYCLES_DEF =
    (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

/* File: hdl/sensor_node_line_modes.sv */
// Per-line mode, drive, sampling and edge event logic with an APB register file
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/100ps
module sensor_node_line_modes
  import line_modes_pkg::*;
#(
  parameter int unsigned NUM_LINES     = NUM_LINES_DEF,
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYCLES_DEF
)
(
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Host computer configuration
  input  wire logic [MODE_W*NUM_LINES-1:0] host_mode,
  // Supply sense of the output supply rail
  input  wire logic                        output_supply_rail,
  // Digital line pins
  input  wire logic [NUM_LINES-1:0]        digital_line_in,
  output logic      [NUM_LINES-1:0]        digital_line_out,
  output logic      [NUM_LINES-1:0]        digital_line_oe_n,
  output logic      [NUM_LINES-1:0]        pullup_en,
  output logic      [NUM_LINES-1:0]        gnd_path_en
);

  localparam int unsigned CNT_W = $clog2(SETTLE_CYCLES + 1);
  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);

  // Pin patterns {oe_n, out, pull-up, ground path}
  localparam logic [3:0] PINS_FLOAT  = 4'h8;
  localparam logic [3:0] PINS_LOW    = 4'h0;
  localparam logic [3:0] PINS_HIGH   = 4'h4;
  localparam logic [3:0] PINS_PULLUP = 4'hA;
  localparam logic [3:0] PINS_GND    = 4'h9;

  // Resolve host default and illegal codes to an effective mode
  function automatic line_mode_t eff_mode(input logic [3:0] sel, input logic [3:0] host);
    logic [3:0] m;
    line_mode_t r;
    m = (sel == MODE_HOST) ? host : sel;
    if (m == MODE_HOST || m > MODE_OUT_PUSH)
    begin
      r = MODE_IN_LOGIC;
    end
    else
    begin
      r = line_mode_t'(m);
    end
    return r;
  endfunction

  // Pin control for one line: {oe_n, out, pull-up, ground path}
  // Undriven lines keep oe_n high so nothing fights an external source
  function automatic logic [3:0] pin_ctl(input line_mode_t m, input logic val,
                                         input logic supply, input logic active);
    logic [3:0] c;
    c = PINS_FLOAT;
    unique case (m)
      MODE_IN_SINK24:  c = PINS_GND;
      MODE_IN_SINK_PM: c = {3'b100, active};
      MODE_IN_LOGIC:   c = PINS_FLOAT;
      MODE_IN_CONTACT: c = {2'b10, active, 1'b0};
      MODE_OUT_SINK:   c = val ? PINS_FLOAT : PINS_LOW;
      MODE_OUT_SOURCE: c = val ? PINS_HIGH : PINS_FLOAT;
      MODE_OUT_OC_PU:  c = val ? PINS_PULLUP : PINS_LOW;
      MODE_OUT_PUSH:
      begin
        if (supply)
        begin
          c = val ? PINS_HIGH : PINS_LOW;
        end
        else
        begin
          c = val ? PINS_FLOAT : PINS_LOW;
        end
      end
      default:         c = PINS_FLOAT;
    endcase
    return c;
  endfunction

  // Registers
  logic [MODE_W*NUM_LINES-1:0] mode_q;
  logic [MODE_W*NUM_LINES-1:0] mode_d;
  logic [NUM_LINES-1:0]        out_q;
  logic [NUM_LINES-1:0]        out_d;
  logic [EDGE_W*NUM_LINES-1:0] edge_q;
  logic [EDGE_W*NUM_LINES-1:0] edge_d;
  logic [NUM_LINES-1:0]        in_q;
  logic [NUM_LINES-1:0]        flag_q;
  logic [NUM_LINES-1:0]        flag_d;
  logic [NUM_LINES-1:0]        valid_q;
  logic [31:0]                 prdata_q;
  smp_state_t                  state_q;
  smp_state_t                  state_d;
  logic [CNT_W-1:0]            cnt_q;
  logic [CNT_W-1:0]            cnt_d;
  logic [NUM_LINES-1:0]        oe_n_q;
  logic [NUM_LINES-1:0]        drv_q;
  logic [NUM_LINES-1:0]        pu_q;
  logic [NUM_LINES-1:0]        gnd_q;

  // Bus decode
  wire setup_ph   = psel & ~penable;
  wire access_ph  = psel & penable;
  wire hit_mode   = (paddr == OFF_MODE);
  wire hit_out    = (paddr == OFF_OUT);
  wire hit_edge   = (paddr == OFF_EDGE);
  wire hit_in     = (paddr == OFF_IN);
  wire hit_sample = (paddr == OFF_SAMPLE);
  wire hit_flag   = (paddr == OFF_FLAG);
  wire hit_status = (paddr == OFF_STATUS);
  wire mapped     = hit_mode | hit_out | hit_edge | hit_in | hit_sample | hit_flag | hit_status;
  wire wr_ok      = access_ph & pwrite & mapped;
  wire rd_flag    = access_ph & ~pwrite & hit_flag;

  // Sample sequencer state
  wire busy       = (state_q != SMP_IDLE);
  wire capture    = (state_q == SMP_CAPTURE);
  wire start      = wr_ok & hit_sample & pwdata[SAMPLE_START_BIT] & ~busy;

  // Read data selection
  wire [31:0] status_word =
    (32'(output_supply_rail) << STATUS_SUPPLY_BIT) | (32'(busy) << STATUS_BUSY_BIT);
  wire [31:0] sample_word = 32'(busy) << SAMPLE_BUSY_BIT;
  wire [31:0] rd_word =
    ({32{hit_mode}}   & 32'(mode_q))                    |
    ({32{hit_out}}    & 32'(out_q))                     |
    ({32{hit_edge}}   & 32'(edge_q))                    |
    ({32{hit_in}}     & 32'(in_q))                      |
    ({32{hit_sample}} & sample_word)                    |
    ({32{hit_flag}}   & 32'(flag_q))                    |
    ({32{hit_status}} & status_word);

  // Flags captured at setup are the ones the read returns and clears
  wire [NUM_LINES-1:0] flag_clr = rd_flag ? prdata_q[NUM_LINES-1:0] : '0;

  assign pready  = access_ph;
  assign pslverr = access_ph & ~mapped;
  assign prdata  = prdata_q;

  // Per-line activity, edge detection and pin control
  logic [NUM_LINES-1:0] cont;
  logic [NUM_LINES-1:0] active;
  logic [NUM_LINES-1:0] event_hit;
  logic [NUM_LINES-1:0] oe_n_d;
  logic [NUM_LINES-1:0] drv_d;
  logic [NUM_LINES-1:0] pu_d;
  logic [NUM_LINES-1:0] gnd_d;

  for (genvar i = 0; i < NUM_LINES; i++)
  begin : g_line
    wire [1:0]  esel = edge_q[EDGE_W*i +: EDGE_W];
    wire [3:0]  ctl;
    wire        rise = digital_line_in[i] & ~in_q[i];
    wire        fall = ~digital_line_in[i] & in_q[i];
    wire        want_rise = (esel == EDGE_RISE);
    wire        want_fall = (esel == EDGE_FALL);
    wire        edge_seen = (want_rise & rise) | (want_fall & fall);

    assign cont[i]      = (esel != EDGE_OFF);
    assign active[i]    = cont[i] | busy;
    assign event_hit[i] = cont[i] & valid_q[i] & edge_seen;
    assign ctl          = pin_ctl(eff_mode(mode_q[MODE_W*i +: MODE_W],
                                           host_mode[MODE_W*i +: MODE_W]),
                                  out_q[i], output_supply_rail, active[i]);
    assign oe_n_d[i]    = ctl[3];
    assign drv_d[i]     = ctl[2];
    assign pu_d[i]      = ctl[1];
    assign gnd_d[i]     = ctl[0];
  end

  // Lines whose input register loads this cycle
  wire [NUM_LINES-1:0] smp_en = cont | {NUM_LINES{capture}};

  // Flags that survive this cycle's read
  wire [NUM_LINES-1:0] flag_keep = flag_q & ~flag_clr;

  // Set wins over the read clear
  assign flag_d = flag_keep | event_hit;

  // Sequencer next state: load applied, wait the settle time, then capture
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    unique case (state_q)
      SMP_IDLE:
      begin
        if (start)
        begin
          state_d = SMP_SETTLE;
          cnt_d   = SETTLE_LAST;
        end
      end
      SMP_SETTLE:
      begin
        if (cnt_q == '0)
          state_d = SMP_CAPTURE;
        else
          cnt_d = cnt_q - 1'b1;
      end
      SMP_CAPTURE:
        state_d = SMP_IDLE;
      default:
        state_d = SMP_IDLE;
    endcase
  end

  // Register next values from APB writes
  always_comb
  begin
    mode_d = mode_q;
    out_d  = out_q;
    edge_d = edge_q;
    if (wr_ok)
    begin
      if (hit_mode)
      begin
        mode_d = pwdata[MODE_W*NUM_LINES-1:0];
      end
      if (hit_out)
      begin
        out_d = pwdata[NUM_LINES-1:0];
      end
      if (hit_edge)
      begin
        edge_d = pwdata[EDGE_W*NUM_LINES-1:0];
      end
    end
  end

  // Software registers
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      mode_q <= RST_MODE[MODE_W*NUM_LINES-1:0];
      out_q  <= RST_OUT[NUM_LINES-1:0];
      edge_q <= RST_EDGE[EDGE_W*NUM_LINES-1:0];
    end
    else
    begin
      mode_q <= mode_d;
      out_q  <= out_d;
      edge_q <= edge_d;
    end
  end

  // Read data, flags and sequencer
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      prdata_q <= 32'h0000_0000;
      flag_q   <= '0;
      state_q  <= SMP_IDLE;
      cnt_q    <= '0;
    end
    else
    begin
      if (setup_ph && !pwrite)
        prdata_q <= rd_word;
      flag_q  <= flag_d;
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // Input sampling: continuous lines every cycle, others at capture
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      in_q    <= '0;
      valid_q <= '0;
    end
    else
    begin
      for (int k = 0; k < NUM_LINES; k++)
      begin
        if (smp_en[k])
          in_q[k] <= digital_line_in[k];
      end
      valid_q <= cont;
    end
  end

  // Registered pin drive
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      oe_n_q <= '1;
      drv_q  <= '0;
      pu_q   <= '0;
      gnd_q  <= '0;
    end
    else
    begin
      oe_n_q <= oe_n_d;
      drv_q  <= drv_d;
      pu_q   <= pu_d;
      gnd_q  <= gnd_d;
    end
  end

  assign digital_line_out  = drv_q;
  assign digital_line_oe_n = oe_n_q;
  assign pullup_en         = pu_q;
  assign gnd_path_en       = gnd_q;

endmodule

/* File: sim/line_modes_assertions.sv */
// Port-level checker for the line mode block, watching line 0
`timescale 1ns/100ps
module line_modes_assertions
  import line_modes_pkg::*;
#(
  parameter int unsigned NUM_LINES = NUM_LINES_DEF
)
(
  // Clock, reset and APB
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // Configuration and pins
  input wire logic [MODE_W*NUM_LINES-1:0] host_mode,
  input wire logic output_supply_rail,
  input wire logic [NUM_LINES-1:0] digital_line_out,
  input wire logic [NUM_LINES-1:0] digital_line_oe_n,
  input wire logic [NUM_LINES-1:0] pullup_en,
  input wire logic [NUM_LINES-1:0] gnd_path_en
);
  logic [3:0] mode_q;
  logic [1:0] edge_q;
  logic [1:0] up_q;
  logic       o_q;
  wire        wr = psel && penable && pwrite;
  wire  [3:0] m0 = (mode_q == 4'h0) ? host_mode[3:0] : mode_q;
  // Shadow of the line 0 settings
  always_ff @(posedge ref_clk)
  begin
    up_q   <= rst_n ? {up_q[0], 1'b1} : 2'h0;
    mode_q <= !rst_n ? 4'h0 : (wr && paddr == OFF_MODE) ? pwdata[3:0] : mode_q;
    edge_q <= !rst_n ? 2'h0 : (wr && paddr == OFF_EDGE) ? pwdata[1:0] : edge_q;
    o_q    <= !rst_n ? 1'b0 : (wr && paddr == OFF_OUT) ? pwdata[0] : o_q;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n || !up_q[1]);
  property p_sink; m0 == 4'h5 |=> digital_line_oe_n[0] == $past(o_q); endproperty
  a_sink: assert property (p_sink) else $error("sink output wrong");
  property p_src; m0 == 4'h6 |=> digital_line_oe_n[0] == !$past(o_q)
    && (digital_line_oe_n[0] || digital_line_out[0]); endproperty
  a_src: assert property (p_src) else $error("source output wrong");
  property p_oc; m0 == 4'h7 |=> pullup_en[0] == $past(o_q)
    && digital_line_oe_n[0] == $past(o_q); endproperty
  a_oc: assert property (p_oc) else $error("open collector wrong");
  property p_push; m0 == 4'h8 && output_supply_rail |=> !digital_line_oe_n[0]
    && digital_line_out[0] == $past(o_q); endproperty
  a_push: assert property (p_push) else $error("push-pull wrong");
  property p_nosup; m0 == 4'h8 && !output_supply_rail |=> digital_line_oe_n[0] == $past(o_q);
  endproperty
  a_nosup: assert property (p_nosup) else $error("push-pull without supply wrong");
  property p_sin; m0 == 4'h1 |=> gnd_path_en[0] && digital_line_oe_n[0]; endproperty
  a_sin: assert property (p_sin) else $error("sink input path off");
  property p_logic; m0 == 4'h3 |=> !gnd_path_en[0] && !pullup_en[0] && digital_line_oe_n[0];
  endproperty
  a_logic: assert property (p_logic) else $error("logic input loaded");
  property p_cont; m0 == 4'h4 && edge_q != 2'h0 |=> pullup_en[0]; endproperty
  a_cont: assert property (p_cont) else $error("continuous pull-up off");
  c_nosup: cover property (m0 == 4'h8 && !output_supply_rail);
  c_cont: cover property (m0 == 4'h4 && edge_q != 2'h0);
  c_smp: cover property (wr && paddr == OFF_SAMPLE);
endmodule
bind sensor_node_line_modes line_modes_assertions #(.NUM_LINES(NUM_LINES)) u_chk (.ref_clk,
  .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .host_mode, .output_supply_rail,
  .digital_line_out, .digital_line_oe_n, .pullup_en, .gnd_path_en);

/* File: sim/line_partner.sv */
// Far side of the lines: sources, pull paths and a floating wire
`timescale 1ns/100ps
module line_partner #(
  parameter int N   = 4,
  parameter int DLY = 4
)
(
  // Clock and block pins
  input  wire logic         clk,
  input  wire logic [N-1:0] oe_n,
  input  wire logic [N-1:0] drv,
  input  wire logic [N-1:0] pu,
  input  wire logic [N-1:0] gnd,
  // Attached sources
  input  wire logic [N-1:0] src_en,
  input  wire logic [N-1:0] src_val,
  input  wire logic [N-1:0] need_load,
  output logic      [N-1:0] line
);
  logic [N-1:0] junk_q = '0;
  int           cnt_q [N];
  always @(posedge clk)
  begin
    junk_q <= ~junk_q;
    for (int i = 0; i < N; i++)
      cnt_q[i] <= gnd[i] ? cnt_q[i] + 1 : 0;
  end
  // Loaded source valid only DLY cycles after the load
  always_comb
    for (int i = 0; i < N; i++)
      line[i] = !oe_n[i] ? drv[i]
              : (src_en[i] && (!need_load[i] || cnt_q[i] >= DLY)) ? src_val[i]
              : (pu[i] || gnd[i]) ? pu[i] : junk_q[i];
endmodule

/* File: sim/sensor_node_line_modes_bench.sv */
// Self-checking bench for the line mode block
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR at %0t: got %h, expected %h", $time, g, e); end end
module sensor_node_line_modes_bench
  import line_modes_pkg::*;
;
  localparam int NL = 4;
  logic ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic output_supply_rail = 1'b0, pready, pslverr, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, mode_w, edge_w, out_w;
  logic [15:0] host_mode = 16'h0;
  logic [NL-1:0] digital_line_in, digital_line_out, digital_line_oe_n, pullup_en, gnd_path_en;
  logic [NL-1:0] src_en = '0, src_val = '0, need_load = '0;
  logic [7:0] offs [4] = '{OFF_MODE, OFF_OUT, OFF_EDGE, 8'h1C};
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  sensor_node_line_modes #(.NUM_LINES(NL), .SETTLE_CYCLES(8)) u_dut (.ref_clk, .rst_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .host_mode,
    .output_supply_rail, .digital_line_in, .digital_line_out, .digital_line_oe_n, .pullup_en,
    .gnd_path_en);
  line_partner #(.N(NL), .DLY(4)) u_far (.clk(ref_clk), .oe_n(digital_line_oe_n),
    .drv(digital_line_out), .pu(pullup_en), .gnd(gnd_path_en), .src_en, .src_val, .need_load,
    .line(digital_line_in));
  always #4 ref_clk = ~ref_clk;
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1)
      @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Pin bits: undriven, high-or-undriven, pull-up, ground path
  function automatic logic [3:0] exp_pins(logic [3:0] m, logic o, logic s, logic a);
    case (m)
      4'h1: exp_pins = 4'b1101;
      4'h2: exp_pins = {3'b110, a};
      4'h4: exp_pins = {2'b11, a, 1'b0};
      4'h5: exp_pins = {o, o, 2'b00};
      4'h6: exp_pins = {~o, 3'b100};
      4'h7: exp_pins = {o, o, o, 1'b0};
      4'h8: exp_pins = {s ? 1'b0 : o, o, 2'b00};
      default: exp_pins = 4'b1100;
    endcase
  endfunction
  task automatic check_pins();
    logic [3:0] m;
    logic [3:0] g;
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i < NL; i++)
    begin
      m = (mode_w[4*i+:4] == 4'h0) ? host_mode[4*i+:4] : mode_w[4*i+:4];
      g = {digital_line_oe_n[i], digital_line_out[i] | digital_line_oe_n[i], pullup_en[i],
           gnd_path_en[i]};
      `CHK(g, exp_pins(m, out_w[i], output_supply_rail, edge_w[2*i+:2] != 2'h0))
    end
  endtask
  initial
  begin
    void'($urandom(32'h0931aaf0));
    host_mode <= 16'($urandom);
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (offs[k])
    begin
      apb(1'b0, offs[k], 32'h0);
      `CHK({err, rd}, {k == 3, 32'h0})
    end
    {mode_w, out_w, edge_w} = '0;
    check_pins();
    repeat (40)
    begin
      mode_w = $urandom & 32'hFFFF;
      out_w = $urandom & 32'hF;
      edge_w = $urandom & 32'hFF;
      host_mode <= 16'($urandom);
      output_supply_rail <= 1'($urandom);
      apb(1'b1, OFF_MODE, mode_w);
      apb(1'b1, OFF_OUT, out_w);
      apb(1'b1, OFF_EDGE, edge_w);
      apb(1'b0, OFF_MODE, 32'h0);
      `CHK(rd, mode_w)
      apb(1'b0, OFF_EDGE, 32'h0);
      `CHK(rd, edge_w)
      check_pins();
    end
    // On-demand sample: loaded source, contact, plain logic
    {mode_w, edge_w} = {32'h3342, 32'h0};
    src_en <= 4'b0101;
    src_val <= 4'b0001;
    need_load <= 4'b0001;
    apb(1'b1, OFF_MODE, mode_w);
    apb(1'b1, OFF_EDGE, edge_w);
    check_pins();
    apb(1'b1, OFF_SAMPLE, 32'h1);
    repeat (2) @(posedge ref_clk);
    `CHK({pullup_en[1], gnd_path_en[0]}, 2'b11)
    rd = 32'h2;
    while (rd[STATUS_BUSY_BIT])
      apb(1'b0, OFF_STATUS, 32'h0);
    apb(1'b0, OFF_IN, 32'h0);
    `CHK(rd[2:0], 3'b011)
    check_pins();
    // Edge events: line 0 rising, line 1 falling
    {mode_w, edge_w} = {32'h3344, 32'h6};
    src_en <= 4'b0011;
    src_val <= 4'b0010;
    need_load <= 4'b0000;
    apb(1'b1, OFF_MODE, mode_w);
    apb(1'b1, OFF_EDGE, edge_w);
    check_pins();
    apb(1'b0, OFF_FLAG, 32'h0);
    src_val <= 4'b0001;
    repeat (10) @(posedge ref_clk);
    apb(1'b0, OFF_FLAG, 32'h0);
    `CHK(rd, 32'h3)
    apb(1'b0, OFF_FLAG, 32'h0);
    `CHK(rd, 32'h0)
    src_val <= 4'b0010;
    repeat (4) @(posedge ref_clk);
    apb(1'b0, OFF_FLAG, 32'h0);
    `CHK(rd, 32'h0)
    end_of_test();
  end
endmodule
